/* hdl/hvwk_filter.sv */
// Per-input threshold crossing filter with programmable time
`timescale 1ns/1ps
`default_nettype none

module hvwk_filter #(
  parameter int CNT_W = 16,
  parameter int T1    = 3200,
  parameter int T2    = 12800
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_lvl,
  input  wire logic i_long,
  input  wire logic i_hold,
  output logic      o_lvl,
  output logic      o_edge
);

  logic [CNT_W-1:0] cnt_q;
  logic             pend_q;
  logic             prev_q;
  logic [CNT_W-1:0] lim;

  assign lim = i_long ? CNT_W'(T2 - 1) : CNT_W'(T1 - 1);

  // ==========================================================================
  // Every crossing restarts the timer; level only accepted once it has held
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= '0;
      pend_q <= 1'b0;
      prev_q <= 1'b0;
      o_lvl  <= 1'b0;
      o_edge <= 1'b0;
    end else begin
      // While frozen, remember the accepted level, so that a change made
      // outside the window still counts as a crossing when it reopens
      prev_q <= i_hold ? o_lvl : i_lvl;
      o_edge <= 1'b0;
      if (i_hold) begin
        cnt_q  <= '0; // Outside the window the input is frozen
        pend_q <= 1'b0;
      end else if (i_lvl != prev_q) begin
        cnt_q  <= '0;
        pend_q <= (i_lvl != o_lvl);
      end else if (pend_q) begin
        if (cnt_q >= lim) begin
          pend_q <= 1'b0;
          o_lvl  <= i_lvl;
          o_edge <= 1'b1;
        end else begin
          cnt_q <= cnt_q + CNT_W'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

/* hdl/hvwk_sync.sv */
// Two-stage synchroniser for the wake comparator outputs
`timescale 1ns/1ps
`default_nettype none

module hvwk_sync #(
  parameter int W = 5
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // ==========================================================================
  // First stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* hdl/hvwk_top.sv */
// Wake input detector: filtering, event latching, levels, pulls and sync
`timescale 1ns/1ps
`default_nettype none

module hvwk_top #(
  parameter int N     = 5,
  parameter int T1    = hvwk_pkg::HVWK_FILT1_CYC,
  parameter int T2    = hvwk_pkg::HVWK_FILT2_CYC
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // APB slave
  input  wire logic         i_psel,
  input  wire logic         i_penable,
  input  wire logic         i_pwrite,
  input  wire logic [7:0]   i_paddr,
  input  wire logic [31:0]  i_pwdata,
  output logic      [31:0]  o_prdata,
  output logic              o_pready,
  output logic              o_pslverr,
  // Pins and system
  input  wire logic [N-1:0] i_hv_wake_pin,
  input  wire logic         i_sense_window,
  output logic      [N-1:0] o_pull_up_en,
  output logic      [N-1:0] o_pull_down_en,
  output logic              o_wake_irq,
  output logic              o_wake_up,
  output logic              o_hs_sync
);

  // ==========================================================================
  // Registers
  logic [31:0]      ctrl_q;
  logic [31:0]      pull_q;
  logic [31:0]      filt_q;
  logic [1:0]       mode_q;
  logic [1:0]       mode_prev_q;
  logic [N-1:0]     stat_q;
  logic [N-1:0]     lvl_q;
  logic [N-1:0]     pin_s;
  logic [N-1:0]     flt_lvl;
  logic [N-1:0]     flt_edge;
  logic [N-1:0]     wake_en;
  logic [N-1:0]     cyc;
  logic [N-1:0]     evt;
  logic [N-1:0]     stat_clr;
  logic             sync_sel;
  logic             wr_acc;
  logic             rd_acc;
  logic             to_normal;
  logic             active_mode;

  assign sync_sel = (ctrl_q[hvwk_pkg::HVWK_CTRL_SYNC_POS +: 2] == hvwk_pkg::HVWK_ENSEL_SYNC);
  assign wr_acc   = i_psel & i_penable & i_pwrite;
  assign rd_acc   = i_psel & i_penable & ~i_pwrite;
  assign active_mode = (mode_q == hvwk_pkg::HVWK_MODE_NORMAL) |
                       (mode_q == hvwk_pkg::HVWK_MODE_STOP);
  assign to_normal = (mode_prev_q == hvwk_pkg::HVWK_MODE_INIT) &
                     (mode_q == hvwk_pkg::HVWK_MODE_NORMAL);
  assign stat_clr = (wr_acc && i_paddr == hvwk_pkg::HVWK_OFS_STAT) ? i_pwdata[N-1:0] : '0;

  // ==========================================================================
  // Pin synchroniser, two flip-flops per comparator output
  hvwk_sync #(
    .W       (N)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_hv_wake_pin),
    .o_sync  (pin_s)
  );

  // ==========================================================================
  // Per-input filter, enable, pull and event logic
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_in
      logic [1:0] psel;
      // Input four in sync use has no wake capability
      if (g == 3) begin : g_four
        assign wake_en[g] = ctrl_q[hvwk_pkg::HVWK_CTRL_EN_POS + g] & ~sync_sel;
      end else begin : g_other
        assign wake_en[g] = ctrl_q[hvwk_pkg::HVWK_CTRL_EN_POS + g];
      end
      assign cyc[g] = ctrl_q[hvwk_pkg::HVWK_CTRL_CYC_POS + g];
      hvwk_filter #(
        .CNT_W  (hvwk_pkg::HVWK_CNT_W),
        .T1     (T1),
        .T2     (T2)
      ) u_flt (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_lvl  (pin_s[g]),
        .i_long (filt_q[g]),
        .i_hold (cyc[g] & ~i_sense_window),
        .o_lvl  (flt_lvl[g]),
        .o_edge (flt_edge[g])
      );
      assign evt[g] = wake_en[g] & (flt_edge[g] |
                      (to_normal & ~cyc[g] & flt_lvl[g]));
      assign psel = pull_q[2*g +: 2];
      // Fifth input keeps its pull-up regardless of the selection
      if (g == 4) begin : g_five
        assign o_pull_up_en[g]   = 1'b1;
        assign o_pull_down_en[g] = 1'b0;
      end else begin : g_pull
        assign o_pull_up_en[g]   = (psel == hvwk_pkg::HVWK_PULL_UP) |
                                   ((psel == hvwk_pkg::HVWK_PULL_AUTO) & pin_s[g]);
        assign o_pull_down_en[g] = (psel == hvwk_pkg::HVWK_PULL_DOWN) |
                                   ((psel == hvwk_pkg::HVWK_PULL_AUTO) & ~pin_s[g]);
      end
    end
  endgenerate

  // ==========================================================================
  // Control registers written over APB
  // Control at 0x00 holds enables, cyclic bits and the input-four select;
  // pulls sit at 0x04, filter selects at 0x08 and the mode at 0x0C.
  // Level and identity offsets ignore writes, so a stray write cannot disturb the
  // level view; a write to the event flags clears each flag written as one
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= hvwk_pkg::HVWK_CTRL_RST;
      pull_q <= hvwk_pkg::HVWK_PULL_RST;
      filt_q <= hvwk_pkg::HVWK_FILT_RST;
      mode_q <= hvwk_pkg::HVWK_MODE_INIT;
    end else if (wr_acc) begin
      case (i_paddr)
        hvwk_pkg::HVWK_OFS_CTRL: ctrl_q <= i_pwdata;
        hvwk_pkg::HVWK_OFS_PULL: pull_q <= i_pwdata;
        hvwk_pkg::HVWK_OFS_FILT: filt_q <= i_pwdata;
        hvwk_pkg::HVWK_OFS_MODE: mode_q <= i_pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Mode history for the Init to Normal check
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_prev_q <= hvwk_pkg::HVWK_MODE_INIT;
    end else begin
      mode_prev_q <= mode_q;
    end
  end

  // ==========================================================================
  // Sticky event flags; a new event beats a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | evt;
    end
  end

  // ==========================================================================
  // Level status: live for static, last window sample for cyclic, zero for input four in sync use
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lvl_q <= '0;
    end else begin
      for (int k = 0; k < N; k++) begin
        if (k == 3 && sync_sel) begin
          lvl_q[k] <= 1'b0;
        end else if (!cyc[k] || i_sense_window) begin
          lvl_q[k] <= pin_s[k];
        end
      end
    end
  end

  // ==========================================================================
  // Event signalling: interrupt in Normal and Stop, wake-up in Sleep only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wake_irq <= 1'b0;
      o_wake_up  <= 1'b0;
      o_hs_sync  <= 1'b0;
    end else begin
      o_wake_irq <= (|evt) & active_mode;
      o_wake_up  <= (|evt) & ~active_mode & (mode_q != hvwk_pkg::HVWK_MODE_INIT);
      o_hs_sync  <= sync_sel & pin_s[3];
    end
  end

  // ==========================================================================
  // APB read path, zero wait states; unmapped reads give zero, with error only above 0x18
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        hvwk_pkg::HVWK_OFS_CTRL: o_prdata <= ctrl_q;
        hvwk_pkg::HVWK_OFS_PULL: o_prdata <= pull_q;
        hvwk_pkg::HVWK_OFS_FILT: o_prdata <= filt_q;
        hvwk_pkg::HVWK_OFS_MODE: o_prdata <= {30'h0, mode_q};
        hvwk_pkg::HVWK_OFS_STAT: o_prdata <= {{(32-N){1'b0}}, stat_q};
        hvwk_pkg::HVWK_OFS_LVL:  o_prdata <= {{(32-N){1'b0}}, lvl_q};
        hvwk_pkg::HVWK_OFS_ID:   o_prdata <= hvwk_pkg::HVWK_ID_VAL;
        default:                 o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & (i_paddr > hvwk_pkg::HVWK_OFS_ID);

  // ==========================================================================
  // Checks
  // Event flags: set by events, cleared only by software
  status_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (stat_q[0] && !stat_clr[0]) |=> stat_q[0])
    else $error("flag lost");
  event_sets_a: assert property (@(posedge i_clk) disable iff (i_rst)
    evt[0] |=> stat_q[0])
    else $error("event not latched");
  stat_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (stat_clr[0] && !evt[0]) |=> !stat_q[0])
    else $error("flag not cleared");
  set_wins_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (evt[0] && stat_clr[0]) |=> stat_q[0])
    else $error("clear beat event");
  // Watches the flag, not the gated event, so a broken enable shows up
  disabled_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!wake_en[1] && !stat_q[1]) |=> !stat_q[1])
    else $error("disabled input fired");

  // Signalling by device mode
  irq_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_wake_irq |-> $past(active_mode))
    else $error("irq outside active mode");
  irq_event_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (|evt && active_mode) |=> o_wake_irq)
    else $error("no interrupt");
  wake_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (|evt && mode_q == hvwk_pkg::HVWK_MODE_SLEEP) |=> o_wake_up)
    else $error("no wake-up");
  init_normal_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (to_normal && wake_en[0] && !cyc[0] && flt_lvl[0]) |=> (stat_q[0] && o_wake_irq))
    else $error("active pin missed at Normal entry");

  // Input four in sync use
  sync_no_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sync_sel[*2] |-> !lvl_q[3])
    else $error("level shown in sync");
  sync_no_wake_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (sync_sel && !stat_q[3]) |=> !stat_q[3])
    else $error("sync input woke");
  hs_sync_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !sync_sel |=> !o_hs_sync)
    else $error("sync output without sync use");

  // Pull sources
  five_pullup_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_pull_up_en[4] && !o_pull_down_en[4])
    else $error("fifth pull changed");
  pull_none_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (pull_q[1:0] == hvwk_pkg::HVWK_PULL_NONE) |-> !(o_pull_up_en[0] || o_pull_down_en[0]))
    else $error("pull source on");
  pull_auto_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (pull_q[1:0] == hvwk_pkg::HVWK_PULL_AUTO) |-> (o_pull_up_en[0] == pin_s[0]))
    else $error("auto pull wrong");

  // Filter and level status
  filter_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(pin_s[0]) |=> !flt_edge[0])
    else $error("edge without filter");
  cyc_freeze_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (cyc[2] && !i_sense_window) |=> !flt_edge[2])
    else $error("edge outside window");
  level_live_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !cyc[1] |=> (lvl_q[1] == $past(pin_s[1])))
    else $error("level not live");
  cyc_level_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (cyc[0] && !i_sense_window) |=> $stable(lvl_q[0]))
    else $error("held level moved");

  // Register writes
  ctrl_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_acc && i_paddr == hvwk_pkg::HVWK_OFS_CTRL) |=> (ctrl_q == $past(i_pwdata)))
    else $error("control write lost");
  filt_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_acc && i_paddr == hvwk_pkg::HVWK_OFS_FILT) |=> (filt_q == $past(i_pwdata)))
    else $error("filter write lost");

  irq_seen_c:   cover property (@(posedge i_clk) disable iff (i_rst) o_wake_irq);
  cyc_evt_c:    cover property (@(posedge i_clk) disable iff (i_rst) cyc[0] && evt[0]);
  wake_seen_c:  cover property (@(posedge i_clk) disable iff (i_rst) o_wake_up);
  init_norm_c:  cover property (@(posedge i_clk) disable iff (i_rst) to_normal && |evt);
  clr_race_c:   cover property (@(posedge i_clk) disable iff (i_rst) |(evt & stat_clr));

endmodule
`default_nettype wire

/* pkg/hvwk_pkg.sv */
// Package of constants and types for the wake input detector
package hvwk_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] HVWK_OFS_CTRL    = 8'h00; // Enables and sense modes
  localparam logic [7:0] HVWK_OFS_PULL    = 8'h04; // Pull select pairs
  localparam logic [7:0] HVWK_OFS_FILT    = 8'h08; // Filter selects
  localparam logic [7:0] HVWK_OFS_MODE    = 8'h0C; // Device mode
  localparam logic [7:0] HVWK_OFS_STAT    = 8'h10; // Wake event flags, write one to clear
  localparam logic [7:0] HVWK_OFS_LVL     = 8'h14; // Level status
  localparam logic [7:0] HVWK_OFS_ID      = 8'h18; // Block identity

  // ==========================================================================
  // Field positions in the control register
  localparam int HVWK_CTRL_EN_POS     = 0;  // Wake enable per input
  localparam int HVWK_CTRL_CYC_POS    = 8;  // Cyclic sense per input
  localparam int HVWK_CTRL_SYNC_POS   = 16; // Two-bit enable select of input four

  // Enable select encoding of input four
  localparam logic [1:0] HVWK_ENSEL_SYNC = 2'h2;

  // ==========================================================================
  // Pull select encoding
  localparam logic [1:0] HVWK_PULL_NONE = 2'h0;
  localparam logic [1:0] HVWK_PULL_DOWN = 2'h1;
  localparam logic [1:0] HVWK_PULL_UP   = 2'h2;
  localparam logic [1:0] HVWK_PULL_AUTO = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] HVWK_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] HVWK_PULL_RST = 32'h0000_0000;
  localparam logic [31:0] HVWK_FILT_RST = 32'h0000_0000;
  localparam logic [31:0] HVWK_ID_VAL   = 32'h0000_5A01; // Arbitrary value

  // ==========================================================================
  // Timing
  localparam int HVWK_CLK_MHZ     = 200;
  localparam int HVWK_FILT1_US    = 16;
  localparam int HVWK_FILT2_US    = 64;
  localparam int HVWK_FILT1_CYC   = HVWK_FILT1_US * HVWK_CLK_MHZ;
  localparam int HVWK_FILT2_CYC   = HVWK_FILT2_US * HVWK_CLK_MHZ;
  localparam int HVWK_CNT_W       = 16;

  // ==========================================================================
  // Device modes
  typedef enum logic [1:0] {
    HVWK_MODE_INIT   = 2'b00,
    HVWK_MODE_NORMAL = 2'b01,
    HVWK_MODE_STOP   = 2'b10,
    HVWK_MODE_SLEEP  = 2'b11
  } hvwk_mode_t;

endpackage

/* testbench/hv_wake_input_detector_bench.sv */
// Self-checking bench for the wake input detector
`timescale 1ns/1ps
`default_nettype none

module hv_wake_input_detector_bench;
  // ==========================================================================
  // Signals
  localparam int         N      = 5;
  localparam logic [7:0] A_CTRL = hvwk_pkg::HVWK_OFS_CTRL;
  localparam logic [7:0] A_PULL = hvwk_pkg::HVWK_OFS_PULL;
  localparam logic [7:0] A_FILT = hvwk_pkg::HVWK_OFS_FILT;
  localparam logic [7:0] A_MODE = hvwk_pkg::HVWK_OFS_MODE;
  localparam logic [7:0] A_STAT = hvwk_pkg::HVWK_OFS_STAT;
  localparam logic [7:0] A_LVL  = hvwk_pkg::HVWK_OFS_LVL;
  logic          i_clk;
  logic          i_rst;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic          win;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic [31:0]   rd;
  logic          pready;
  logic          pslverr;
  logic          er;
  logic          irq;
  logic          wup;
  logic          hs_sync;
  logic [N-1:0]  pins;
  logic [N-1:0]  pu;
  logic [N-1:0]  pd;
  int            err_total = 0;
  int            n_checks = 0;
  int            irq_n = 0;
  int            wup_n = 0;
  int            ib;
  int            wb;

  // Short filter counts keep the run brief
  hvwk_top #(.N(N), .T1(4), .T2(8)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_hv_wake_pin(pins), .i_sense_window(win), .o_pull_up_en(pu),
    .o_pull_down_en(pd), .o_wake_irq(irq), .o_wake_up(wup), .o_hs_sync(hs_sync));
  hvwk_pin_model #(.N(N)) u_pins (.i_clk(i_clk), .o_pin(pins));

  // ==========================================================================
  // Clock and pulse counters
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Counted on the falling edge, clear of the rising-edge updates
  always @(negedge i_clk) begin
    if (irq === 1'b1) irq_n++;
    if (wup === 1'b1) wup_n++;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) chk(32'h0, 32'h1, "no pready");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask

  task automatic mark;
    ib = irq_n;
    wb = wup_n;
  endtask

  // Pulses seen since mark, judged after a window well past the filter
  task automatic evt(input int ei, input int ew, input string m);
    repeat (30) @(posedge i_clk);
    chk(irq_n - ib, ei, m);
    chk(wup_n - wb, ew, m);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    rdchk(hvwk_pkg::HVWK_OFS_ID, hvwk_pkg::HVWK_ID_VAL, "id");
    rdchk(A_CTRL, hvwk_pkg::HVWK_CTRL_RST, "ctrl reset");
    rdchk(A_PULL, hvwk_pkg::HVWK_PULL_RST, "pull reset");
    rdchk(A_FILT, hvwk_pkg::HVWK_FILT_RST, "filt reset");
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk({pu, pd}, {5'h10, 5'h00}, "reset pulls");
    chk({31'h0, hs_sync}, 32'h0, "sync idle");
  endtask

  task automatic t_init;
    wr(A_CTRL, 32'h1);
    mark();
    u_pins.set_pin(0, 1'b1);
    evt(0, 0, "init quiet");
    mark();
    wr(A_MODE, 32'h1);
    evt(1, 0, "init to normal");
    rdchk(A_STAT, 32'h1, "init stat");
    wr(A_STAT, 32'h1F);
    rdchk(A_STAT, 32'h0, "clear");
  endtask

  task automatic t_edges;
    mark();
    u_pins.set_pin(0, 1'b0);
    evt(1, 0, "falling");
    rdchk(A_STAT, 32'h1, "fall stat");
    mark();
    u_pins.set_pin(0, 1'b1);
    evt(1, 0, "rising");
    rdchk(A_STAT, 32'h1, "flag held");
    wr(A_STAT, 32'h1);
    rdchk(A_STAT, 32'h0, "w1c");
  endtask

  task automatic t_filter;
    wr(A_CTRL, 32'h3);
    wr(A_FILT, 32'h2);
    mark();
    u_pins.bounce(0, 2);
    evt(0, 0, "glitch");
    mark();
    u_pins.bounce(0, 6);
    evt(2, 0, "short filter pulse");
    mark();
    u_pins.bounce(1, 6);
    evt(0, 0, "long filter pulse");
    mark();
    u_pins.set_pin(1, 1'b1);
    evt(1, 0, "long filter edge");
    rdchk(A_STAT, 32'h3, "filter stat");
    wr(A_STAT, 32'h3);
  endtask

  task automatic t_disabled;
    mark();
    u_pins.set_pin(2, 1'b1);
    evt(0, 0, "disabled");
    rdchk(A_STAT, 32'h0, "disabled stat");
  endtask

  task automatic t_modes;
    wr(A_MODE, 32'h3);
    mark();
    u_pins.set_pin(1, 1'b0);
    evt(0, 1, "sleep wake");
    wr(A_MODE, 32'h2);
    mark();
    u_pins.set_pin(1, 1'b1);
    evt(1, 0, "stop irq");
    wr(A_STAT, 32'h1F);
    wr(A_MODE, 32'h1);
  endtask

  // Input three on automatic, four pulled up, five asked for auto but fixed
  task automatic t_pull;
    wr(A_PULL, 32'h3B4);
    repeat (2) @(posedge i_clk);
    chk({pu, pd}, {5'h1C, 5'h02}, "pull codes");
    u_pins.set_pin(2, 1'b0);
    repeat (4) @(posedge i_clk);
    chk({pu, pd}, {5'h18, 5'h06}, "auto pull");
  endtask

  task automatic t_level;
    rdchk(A_LVL, {27'h0, pins}, "live level");
    wr(A_CTRL, 32'h0002_000F);
    mark();
    u_pins.set_pin(3, 1'b1);
    evt(0, 0, "sync no wake");
    chk({31'h0, hs_sync}, 32'h1, "sync follows");
    rdchk(A_LVL, {27'h0, pins & 5'h17}, "sync level");
  endtask

  // Window primed once so the held sample is known
  task automatic t_cyclic;
    wr(A_CTRL, 32'h0000_0101);
    win <= 1'b1;
    repeat (20) @(posedge i_clk);
    win <= 1'b0;
    wr(A_STAT, 32'h1F);
    mark();
    u_pins.set_pin(0, 1'b0);
    evt(0, 0, "outside window");
    apb(1'b0, A_LVL, 32'h0);
    chk({31'h0, rd[0]}, 32'h1, "held level");
    mark();
    win <= 1'b1;
    evt(1, 0, "inside window");
    win <= 1'b0;
    apb(1'b0, A_LVL, 32'h0);
    chk({31'h0, rd[0]}, 32'h0, "new sample");
  endtask

  // ==========================================================================
  // Verdict, main sequence and watchdog
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    i_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    win = 1'b0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_init();
    t_edges();
    t_filter();
    t_disabled();
    t_modes();
    t_pull();
    t_level();
    t_cyclic();
    close_out();
  end

  // Whole run needs about 600 cycles; this allows over ten times that
  initial begin
    #50000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire

/* testbench/hvwk_pin_model.sv */
// Model of the switches and sensors wired to the wake pins
`timescale 1ns/1ps
`default_nettype none

module hvwk_pin_model #(
  parameter int N = 5
) (
  input  wire logic         i_clk,
  output logic      [N-1:0] o_pin
);
  // ==========================================================================
  // Switch state
  // Input five idles high because of its fixed pull-up
  initial o_pin = {1'b1, {(N-1){1'b0}}};

  // Contact moves just after a clock edge, never on the sampling edge
  task automatic set_pin(input int idx, input logic v);
    @(posedge i_clk);
    o_pin[idx] <= v;
  endtask

  // Contact bounce: away for len cycles, then back to where it was
  task automatic bounce(input int idx, input int len);
    set_pin(idx, !o_pin[idx]);
    repeat (len - 1) @(posedge i_clk);
    set_pin(idx, !o_pin[idx]);
  endtask
endmodule
`default_nettype wire
